/* File: hw/sro_rx_out.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// - each lane in own 32-bit output slice
// - earliest octet sits in lowest byte
// - first-byte marker one cycle before data
// - start aligned to byte 0 when multiples
// - last-byte marker, same encoding and timing
// - one error flag per byte, lane ordered
// - error flags one cycle before data
// - no frame store or replay on errors
// - sync request low until comma aligned
// - subclass 1 waits on system reference
// - one marker applies to all lanes
// - stream clock and low reset driven out
// - positional marker, one bit per byte
// - several marker bits for short frames
module sro_rx_out
  import sro_pkg::*;
#(
  parameter int LANES = 4  // serial lanes
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  // aligned lane data from the deframer
  input  wire logic [LANE_W*LANES-1:0] lane_word_in,
  input  wire logic                    lane_word_valid,
  input  wire logic [4*LANES-1:0]      lane_byte_err,
  input  wire logic                    comma_aligned,
  // configuration
  input  wire logic [1:0]              subclass_mode,
  input  wire logic [F_W-1:0]          frame_octets_m1,
  input  wire logic [F_W-1:0]          multiframe_octets,
  input  wire logic [F_W-1:0]          rx_buffer_delay,
  // timing reference
  input  wire logic                    sysref_in,
  // stream to user logic
  output logic                         stream_clk,
  output logic                         stream_rst_n,
  output logic [LANE_W*LANES-1:0]      stream_data,
  output logic                         stream_valid,
  output logic [3:0]                   frame_first_byte_marker,
  output logic [3:0]                   frame_last_byte_marker,
  output logic [4*LANES-1:0]           byte_error,
  // to far transmitter
  output logic                         sync_req_n
);

  // reduce v modulo f by bounded subtraction
  function automatic logic [POS_W-1:0] mod_f(input logic [POS_W-1:0] v,
                                             input logic [POS_W-1:0] f);
    logic [POS_W-1:0] r;
    r = v;
    for (int k = 0; k < MOD_STEPS; k++) begin
      if (r >= f) begin
        r = r - f;
      end
    end
    return r;
  endfunction : mod_f

  sro_state_t             state_r;     // link start state
  sro_state_t             state_nxt;
  logic                   first_r;     // next word is first of the run
  logic [POS_W-1:0]       cnt_r;       // frame position of byte 0
  logic [POS_W-1:0]       cnt_nxt;
  logic [POS_W-1:0]       f_len;       // octets per frame
  logic [1:0]             start_pos;   // byte holding first octet
  logic                   take;        // word enters the stream
  logic [3:0]             sof_nxt;
  logic [3:0]             eof_nxt;
  logic [LANE_W*LANES-1:0] word_s1_r;  // first data stage, level with the markers
  logic                   valid_s1_r;
  logic                   sync_r;
  logic                   rst_n_r;

  assign f_len     = POS_W'(frame_octets_m1) + POS_W'(1);
  // first octet offset; zero when both sizes are multiples of four
  assign start_pos = multiframe_octets[1:0] + rx_buffer_delay[1:0];
  assign take      = (state_r == SRO_RUN) && lane_word_valid;

  // the stream clock is the core clock, shared by all lanes
  assign stream_clk   = core_clk;
  assign stream_rst_n = rst_n_r;
  assign sync_req_n   = sync_r;

  // start sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SRO_WAIT_ALIGN: begin
        if (comma_aligned) begin
          state_nxt = SRO_WAIT_REF;
        end
      end
      SRO_WAIT_REF: begin
        // subclass 1 may only start on the reference
        if (!comma_aligned) begin
          state_nxt = SRO_WAIT_ALIGN;
        end else if (subclass_mode != SUBCLASS_1 || sysref_in) begin
          state_nxt = SRO_RUN;
        end
      end
      SRO_RUN: begin
        if (!comma_aligned) begin
          state_nxt = SRO_WAIT_ALIGN;
        end
      end
      default: begin
        state_nxt = SRO_WAIT_ALIGN;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= SRO_WAIT_ALIGN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // sync request held low until alignment is reached
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync_r <= 1'b0;
    end else begin
      sync_r <= comma_aligned;
    end
  end

  // stream reset, released one edge after the core reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rst_n_r <= 1'b0;
    end else begin
      rst_n_r <= 1'b1;
    end
  end

  // per byte marker decode, one shared pattern for all lanes
  always_comb begin
    logic [POS_W-1:0] p;
    p       = '0;
    sof_nxt = 4'h0;
    eof_nxt = 4'h0;
    for (int j = 0; j < LANE_BYTES; j++) begin
      if (first_r) begin
        // reduced as well: frames shorter than a word start more than once in it
        // bytes below start_pos wrap here, but the gate below masks them
        p = mod_f(POS_W'(j) - POS_W'(start_pos), f_len);
      end else begin
        p = mod_f(cnt_r + POS_W'(j), f_len);
      end
      // bytes below the first octet carry no frame yet
      if (take && !(first_r && j < int'(start_pos))) begin
        sof_nxt[j] = (p == '0);
        eof_nxt[j] = (p == f_len - POS_W'(1));
      end
    end
  end

  // frame position of the next word
  always_comb begin
    if (first_r) begin
      cnt_nxt = mod_f(POS_W'(LANE_BYTES) - POS_W'(start_pos), f_len);
    end else begin
      cnt_nxt = mod_f(cnt_r + POS_W'(LANE_BYTES), f_len);
    end
  end

  // frame counter
  always_ff @(posedge core_clk) begin
    if (sys_rst || state_r != SRO_RUN) begin
      cnt_r   <= '0;
      first_r <= 1'b1;
    end else if (lane_word_valid) begin
      cnt_r   <= cnt_nxt;
      first_r <= 1'b0;
    end
  end

  // markers and error flags lead the data by one cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      frame_first_byte_marker <= 4'h0;
      frame_last_byte_marker  <= 4'h0;
      byte_error              <= '0;
    end else begin
      frame_first_byte_marker <= sof_nxt;
      frame_last_byte_marker  <= eof_nxt;
      byte_error <= take ? lane_byte_err : '0;
    end
  end

  // two data stages; words pass unchanged, nothing kept for replay
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      word_s1_r    <= '0;
      valid_s1_r   <= 1'b0;
      stream_data  <= '0;
      stream_valid <= 1'b0;
    end else begin
      word_s1_r    <= lane_word_in;
      valid_s1_r   <= take;
      stream_data  <= word_s1_r;
      stream_valid <= valid_s1_r;
    end
  end

  // checks
  sequence s_take;
    take;
  endsequence

  sequence s_data_out;
    ##2 stream_valid && stream_data == $past(lane_word_in, 2);
  endsequence

  property p_data_slices;
    @(posedge core_clk) disable iff (sys_rst)
      s_take |-> s_data_out;
  endproperty
  a_data_slices: assert property (p_data_slices)
    else $error("lane word not passed to its slice");

  property p_err_early;
    @(posedge core_clk) disable iff (sys_rst)
      take |=> byte_error == $past(lane_byte_err) ##1 stream_valid;
  endproperty
  a_err_early: assert property (p_err_early)
    else $error("error flags not one cycle before data");

  property p_mark_early;
    @(posedge core_clk) disable iff (sys_rst)
      (frame_first_byte_marker != 4'h0) |=> stream_valid;
  endproperty
  a_mark_early: assert property (p_mark_early)
    else $error("frame first marker without following data");

  property p_last_early;
    @(posedge core_clk) disable iff (sys_rst)
      (frame_last_byte_marker != 4'h0) |=> stream_valid;
  endproperty
  a_last_early: assert property (p_last_early)
    else $error("frame last marker without following data");

  property p_start_byte0;
    @(posedge core_clk) disable iff (sys_rst)
      (take && first_r && multiframe_octets[1:0] == 2'h0 &&
       rx_buffer_delay[1:0] == 2'h0) |=> frame_first_byte_marker[0];
  endproperty
  a_start_byte0: assert property (p_start_byte0)
    else $error("first octet not in byte 0");

  property p_positional;
    @(posedge core_clk) disable iff (sys_rst)
      (take && !first_r) |=>
        frame_last_byte_marker[2:0] == frame_first_byte_marker[3:1];
  endproperty
  a_positional: assert property (p_positional)
    else $error("frame end and next start not adjacent");

  property p_short_frame;
    @(posedge core_clk) disable iff (sys_rst)
      (take && frame_octets_m1 == '0 && !first_r) |=>
        frame_first_byte_marker == MARK_ALL;
  endproperty
  a_short_frame: assert property (p_short_frame)
    else $error("single octet frames not fully marked");

  // words taken before the drop may still drain; only later ones are blocked
  sequence s_sync_drop;
    !sync_req_n ##2 !stream_valid;
  endsequence

  property p_sync_low;
    @(posedge core_clk) disable iff (sys_rst)
      !comma_aligned |=> s_sync_drop;
  endproperty
  a_sync_low: assert property (p_sync_low)
    else $error("sync request or data while not aligned");

  property p_sysref_start;
    @(posedge core_clk) disable iff (sys_rst)
      (state_r == SRO_WAIT_REF && subclass_mode == SUBCLASS_1 && !sysref_in)
        |=> state_r != SRO_RUN;
  endproperty
  a_sysref_start: assert property (p_sysref_start)
    else $error("subclass 1 start without reference");

  property p_rst_out;
    @(posedge core_clk) disable iff (sys_rst)
      $past(sys_rst) |-> !stream_rst_n ##1 stream_rst_n;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("stream reset not released one edge late");

endmodule : sro_rx_out
`default_nettype wire

/* File: hw/sro_pkg.sv */
package sro_pkg;
  localparam int BYTE_W     = 8;  // octet width
  localparam int LANE_BYTES = 4;  // octets per lane word
  localparam int LANE_W     = 32; // lane word width
  localparam int F_W        = 8;  // frame size field, octets minus one
  localparam int POS_W      = 10; // octet position arithmetic width
  localparam int MOD_STEPS  = 5;  // subtractions that cover cnt+4 < 5*F
  localparam logic [1:0] SUBCLASS_1 = 2'h1; // deterministic latency mode
  localparam logic [3:0] MARK_ALL   = 4'hF; // every byte starts a frame
  // link start sequence, gray along the usual path
  typedef enum logic [1:0] {
    SRO_WAIT_ALIGN = 2'b00,
    SRO_WAIT_REF   = 2'b01,
    SRO_RUN        = 2'b11
  } sro_state_t;
endpackage : sro_pkg

/* File: dv/sro_user_model.sv */
`timescale 1ns/1ns
`default_nettype none
// user side: collects stream words with their early side info
module sro_user_model
  import sro_pkg::*;
#(
  parameter int LANES = 4  // serial lanes
) (
  // stream from the receiver
  input  wire logic                    stream_clk,
  input  wire logic                    stream_rst_n,
  input  wire logic [LANE_W*LANES-1:0] stream_data,
  input  wire logic                    stream_valid,
  input  wire logic [3:0]              frame_first_byte_marker,
  input  wire logic [3:0]              frame_last_byte_marker,
  input  wire logic [4*LANES-1:0]      byte_error
);
  logic [3:0]              first_q;  // markers of the previous cycle
  logic [3:0]              last_q;
  logic [4*LANES-1:0]      err_q;    // errors of the previous cycle
  logic [LANE_W*LANES-1:0] qd[$];    // received words in order
  logic [3:0]              qf[$];
  logic [3:0]              ql[$];
  logic [4*LANES-1:0]      qe[$];
  // side info leads data by one cycle, so pair it with the next beat
  always @(posedge stream_clk) begin
    if (stream_rst_n === 1'b1 && stream_valid === 1'b1) begin
      qd.push_back(stream_data);
      qf.push_back(first_q);
      ql.push_back(last_q);
      qe.push_back(err_q);
    end
    first_q <= frame_first_byte_marker;
    last_q  <= frame_last_byte_marker;
    err_q   <= byte_error;
  end
endmodule : sro_user_model
`default_nettype wire

/* File: dv/sro_rx_out_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module sro_rx_out_tb
  import sro_pkg::*;
;
  localparam int L = 4;  // lanes under test
  logic                core_clk = 1'b0;
  logic                sys_rst = 1'b1;
  logic [LANE_W*L-1:0] lane_word_in = '0;
  logic                lane_word_valid = 1'b0;
  logic [4*L-1:0]      lane_byte_err = '0;
  logic                comma_aligned = 1'b0;
  logic [1:0]          subclass_mode = 2'h0;
  logic [7:0]          fm1 = 8'h03, mf = 8'h00, dly = 8'h00;
  logic                sysref_in = 1'b0;
  logic                s_clk, s_rst_n, s_valid, sync_n;
  logic [LANE_W*L-1:0] s_data;
  logic [3:0]          s_first, s_last;
  logic [4*L-1:0]      s_err;
  int                  bad_count = 0, n_compared = 0, cyc = 0, base;
  // 50 ns clock
  initial forever #25 core_clk = ~core_clk;
  sro_rx_out #(.LANES(L)) i_sro_rx_out (.core_clk(core_clk), .sys_rst(sys_rst),
    .lane_word_in(lane_word_in), .lane_word_valid(lane_word_valid),
    .lane_byte_err(lane_byte_err), .comma_aligned(comma_aligned),
    .subclass_mode(subclass_mode), .frame_octets_m1(fm1), .multiframe_octets(mf),
    .rx_buffer_delay(dly), .sysref_in(sysref_in), .stream_clk(s_clk),
    .stream_rst_n(s_rst_n), .stream_data(s_data), .stream_valid(s_valid),
    .frame_first_byte_marker(s_first), .frame_last_byte_marker(s_last),
    .byte_error(s_err), .sync_req_n(sync_n));
  sro_user_model #(.LANES(L)) i_sro_user_model (.stream_clk(s_clk),
    .stream_rst_n(s_rst_n), .stream_data(s_data), .stream_valid(s_valid),
    .frame_first_byte_marker(s_first), .frame_last_byte_marker(s_last),
    .byte_error(s_err));
  task automatic chk_bits(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bits
  task automatic chk_data(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data
  // distinct bytes per lane and word, so swaps and replays show
  function automatic logic [127:0] wd(input int k);
    return {32'h33323130, 32'h23222120, 32'h13121110, 32'h03020100} ^ {16{k[7:0]}};
  endfunction : wd
  task automatic link_up(input logic [1:0] sc, input logic [7:0] f, m, d);
    @(posedge core_clk);
    comma_aligned <= 1'b0;
    subclass_mode <= sc;
    fm1 <= f;
    mf <= m;
    dly <= d;
    repeat (2) @(posedge core_clk);
    #1 chk_bits({15'h0, sync_n}, 16'h0000);
    @(posedge core_clk);
    comma_aligned <= 1'b1;
    @(posedge core_clk);
    #1 chk_bits({15'h0, sync_n}, 16'h0001);
  endtask : link_up
  task automatic send_words(input int n, input logic [15:0] e);
    for (int k = 0; k < n; k++) begin
      @(posedge core_clk);
      lane_word_valid <= 1'b1;
      lane_word_in <= wd(k);
      lane_byte_err <= (k == 0) ? e : 16'h0000;
    end
    @(posedge core_clk);
    lane_word_valid <= 1'b0;
    lane_byte_err <= 16'hFFFF;  // idle junk must never reach the user
    repeat (4) @(posedge core_clk);
  endtask : send_words
  // link up, stream n words, judge every word and its side info
  task automatic run_case(input logic [7:0] f, m, d, input int n, input logic [15:0] e,
                          input logic [3:0] f0, fn, l0, ln);
    link_up(2'h0, f, m, d);
    base = i_sro_user_model.qd.size();
    send_words(n, e);
    chk_bits(16'(i_sro_user_model.qd.size() - base), 16'(n));
    for (int k = 0; k < n; k++) begin
      chk_data(i_sro_user_model.qd[base+k], wd(k));
      chk_bits(i_sro_user_model.qe[base+k], (k == 0) ? e : 16'h0000);
      chk_bits({12'h0, i_sro_user_model.qf[base+k]}, {12'h0, (k == 0) ? f0 : fn});
      chk_bits({12'h0, i_sro_user_model.ql[base+k]}, {12'h0, (k == 0) ? l0 : ln});
    end
  endtask : run_case
  task automatic t_reset();
    @(posedge core_clk);
    #1 chk_bits({13'h0, s_rst_n, sync_n, s_valid}, 16'h0000);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1 chk_bits({14'h0, s_rst_n, sync_n}, 16'h0002);
    chk_bits({15'h0, s_clk}, {15'h0, core_clk});
  endtask : t_reset
  task automatic t_frame4();
    run_case(8'h03, 8'h00, 8'h00, 3, 16'h8001, 4'h1, 4'h1, 4'h8, 4'h8);
  endtask : t_frame4
  task automatic t_short();
    run_case(8'h00, 8'h04, 8'h04, 2, 16'h0010, 4'hF, 4'hF, 4'hF, 4'hF);
    run_case(8'h01, 8'h00, 8'h00, 2, 16'h0000, 4'h5, 4'h5, 4'hA, 4'hA);
  endtask : t_short
  task automatic t_offset();
    // start byte 3: first word holds no frame end
    run_case(8'h03, 8'h01, 8'h02, 2, 16'h0100, 4'h8, 4'h8, 4'h0, 4'h4);
  endtask : t_offset
  task automatic t_sysref();
    link_up(SUBCLASS_1, 8'h03, 8'h00, 8'h00);
    base = i_sro_user_model.qd.size();
    send_words(2, 16'h0000);
    chk_bits(16'(i_sro_user_model.qd.size() - base), 16'h0000);
    @(posedge core_clk);
    sysref_in <= 1'b1;  // driven on the core clock
    send_words(1, 16'h0000);
    sysref_in <= 1'b0;
    chk_bits(16'(i_sro_user_model.qd.size() - base), 16'h0001);
    chk_data(i_sro_user_model.qd[base], wd(0));
  endtask : t_sysref
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // hang guard, well above the about 70 cycles needed
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    t_reset();
    t_frame4();
    t_short();
    t_offset();
    t_sysref();
    final_report();
  end
endmodule : sro_rx_out_tb
`default_nettype wire
